//--- design/uart_pkg.sv
// constants, frame carrier and state codes of the serial port
// assumes one 10 MHz system clock and a byte-wide processor port
package uart_pkg;
  // register addresses
  localparam logic [15:0] ADDR_MODE = 16'hFF50;
  localparam logic [15:0] ADDR_ERR = 16'hFF53;
  localparam logic [15:0] ADDR_TXSTAT = 16'hFF54;
  localparam logic [15:0] ADDR_TXBUF = 16'hFF55;
  localparam logic [15:0] ADDR_CKS = 16'hFF56;
  localparam logic [15:0] ADDR_BAUD = 16'hFF57;
  localparam logic [15:0] ADDR_CTRL = 16'hFF58;
  localparam logic [15:0] ADDR_RXBUF = 16'hFF59;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h16;
  localparam logic [7:0] BAUD_RST = 8'hFF;
  localparam logic [3:0] CKS_RST = 4'h0;
  localparam logic [3:0] CKS_MAX = 4'hA;
  // mode register fields
  localparam int MODE_PWR = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_ROUTE = 0;
  // control register fields, upper three read as zero
  localparam int CTRL_DIR = 1;
  localparam int CTRL_INV = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h1F;
  // status fields
  localparam int TXST_BUF_FULL = 1;
  localparam int TXST_SHIFT = 0;
  localparam int ERR_PARITY = 2;
  localparam int ERR_FRAME = 1;
  localparam int ERR_OVERRUN = 0;
  // parity select codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam int TX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic char8;
    logic [1:0] parity;
    logic stop2;
    logic lsb_first;
    logic invert;
  } frame_cfg_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_t;
endpackage

//--- design/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; clr empties it in one cycle
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers
  always_ff @(posedge clk) begin
    if (!rstn || clr) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge clk) begin
    if (push) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

//--- design/uart_ctrl.sv
// serial port: mode/control registers, framing transmitter and receiver
// assumes a byte-wide processor port with byte and single-bit writes
//
// Functional notes
// - all three enables clear means stopped, no serial traffic.
// - stopped port leaves both pins to the general port.
// - reset loads mode register with 01H.
// - power off stops the internal clock and clears the core.
// - transmit enable off holds transmitter in reset.
// - receive enable off holds receiver in reset.
// - power off drives output high, input seen as high.
// - power off clears error, transmit status, control bits 7:6, receive buffer.
// - one byte per frame after a start bit, full duplex.
// - transmit buffer write with power and transmit enabled starts a frame.
// - start, 7 or 8 data, optional parity, 1 or 2 stops.
// - mode fields set length and parity for both directions, stop count for transmit only.
// - control bit 1 picks LSB or MSB first, both directions.
// - control bit 0 inverts the serial output.
// - mode register takes bit writes and byte writes.
// - even parity: transmit makes ones even, receive flags odd.
// - odd parity: transmit makes ones odd, receive flags even.
// - transmit done pulse as soon as the last stop bit ends.
// - output idles high after power on (low when control bit 0 inverts it), framing bits added by hardware.
`timescale 1ns/10ps
`default_nettype none
module uart_ctrl
  import uart_pkg::*;
#(
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // processor port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_bit_wr,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic cpu_bit_val,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata_r,
  // serial pins and pin ownership
  input wire logic serial_in_pin,
  output logic serial_out_pin_r,
  output logic out_pin_own_r,
  output logic in_pin_own_r,
  // event pulses
  output logic transmit_done_irq_r,
  output logic receive_done_irq_r,
  output logic receive_error_irq_r
);
  logic [7:0] mode_r, ctrl_r, baud_r, err_r, rxbuf_r;
  logic [3:0] cks_r;
  logic pwr, txe_on, rxe_on, wr_any;
  frame_cfg_t cfg;
  logic [10:0] pre_r, pre_lim;
  logic tick_r;
  logic [8:0] bit_lim, half_lim;
  tx_state_t tx_state_r;
  rx_state_t rx_state_r;
  logic [8:0] tx_cnt_r, rx_cnt_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [7:0] tx_sh_r, rx_sh_r, data_mask, fifo_data;
  logic tx_lvl, tx_par, fifo_valid, fifo_ready, fifo_push, tx_end, rx_end;
  logic rx_s1_r, rx_s2_r, rx_prev_r, rx_in, rx_par_r, rx_full_r;
  logic rd_rx, rd_err, pe, fe, ov;

  // single decode of the write address, used for every register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction

  // byte write replaces, bit write touches one bit only
  function automatic logic [7:0] merge(input logic [7:0] old, input logic bw,
                                       input logic [2:0] sel, input logic v,
                                       input logic [7:0] d);
    logic [7:0] r;
    r = old;
    if (bw) r[sel] = v;
    else r = d;
    return r;
  endfunction

  // position of character bit n on the wire
  function automatic logic [2:0] bit_index(input frame_cfg_t c, input logic [2:0] n);
    logic [2:0] top;
    top = c.char8 ? 3'h7 : 3'h6;
    return c.lsb_first ? n : 3'(top - n);
  endfunction

  assign pwr = mode_r[MODE_PWR];
  assign txe_on = pwr && mode_r[MODE_TXE];
  assign rxe_on = pwr && mode_r[MODE_RXE];
  assign wr_any = cpu_wr || cpu_bit_wr;
  assign cfg = '{mode_r[MODE_CL], mode_r[MODE_PS_HI:MODE_PS_LO], mode_r[MODE_SL],
                 ctrl_r[CTRL_DIR], ctrl_r[CTRL_INV]};
  assign data_mask = cfg.char8 ? 8'hFF : 8'h7F;
  assign rd_rx = cpu_rd && hit(cpu_addr, ADDR_RXBUF);
  assign rd_err = cpu_rd && hit(cpu_addr, ADDR_ERR);

  // mode register, the enables are cleared only by reset or software
  always_ff @(posedge sys_clk) begin
    if (!rstn) mode_r <= MODE_RST;
    else if (wr_any && hit(cpu_addr, ADDR_MODE))
      mode_r <= merge(mode_r, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata);
  end

  // control, divider and clock select; break-field bits read as zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST & CTRL_WMASK;
      baud_r <= BAUD_RST;
      cks_r <= CKS_RST;
    end else begin
      if (wr_any && hit(cpu_addr, ADDR_CTRL))
        ctrl_r <= merge(ctrl_r, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata) & CTRL_WMASK;
      else if (!pwr) ctrl_r[7:6] <= 2'h0;
      if (cpu_wr && hit(cpu_addr, ADDR_BAUD)) baud_r <= cpu_wdata;
      if (cpu_wr && hit(cpu_addr, ADDR_CKS))
        cks_r <= (cpu_wdata[3:0] > CKS_MAX) ? CKS_MAX : cpu_wdata[3:0];
    end
  end

  // prescaler stands still with power off, so no tick reaches the core
  assign pre_lim = (11'h001 << cks_r) - 11'h001;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !pwr) begin
      pre_r <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= pre_r == pre_lim;
      pre_r <= (pre_r == pre_lim) ? 11'h000 : pre_r + 11'h001;
    end
  end

  // one bit lasts twice the divider count in ticks
  assign bit_lim = {baud_r, 1'b0} - 9'h001;
  assign half_lim = {1'b0, baud_r} - 9'h001;

  // transmit queue, dropped writes when full show in the status bit
  assign fifo_push = cpu_wr && hit(cpu_addr, ADDR_TXBUF) && txe_on;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk(sys_clk),
    .rstn(rstn),
    .clr(!txe_on),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data(cpu_wdata),
    .out_valid(fifo_valid),
    .out_ready(tx_state_r == TX_IDLE),
    .out_data(fifo_data)
  );

  // transmit level: start low, data, parity, stops and idle high
  always_comb begin
    tx_par = 1'b0;
    unique case (cfg.parity)
      PAR_EVEN: tx_par = ^(tx_sh_r & data_mask);
      PAR_ODD: tx_par = ~^(tx_sh_r & data_mask);
      PAR_ZERO: tx_par = 1'b0;
      PAR_NONE: tx_par = 1'b0;
    endcase
    unique case (tx_state_r)
      TX_START: tx_lvl = 1'b0;
      TX_DATA: tx_lvl = tx_sh_r[bit_index(cfg, tx_bit_r)];
      TX_PAR: tx_lvl = tx_par;
      default: tx_lvl = 1'b1;
    endcase
  end

  assign tx_end = tick_r && tx_cnt_r == bit_lim;

  // transmitter, one frame at a time from the queue
  always_ff @(posedge sys_clk) begin
    if (!rstn || !txe_on) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= 9'h000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
    end else if (tx_state_r == TX_IDLE) begin
      if (fifo_valid) begin
        tx_sh_r <= fifo_data;
        tx_state_r <= TX_START;
      end
    end else if (tick_r) begin
      tx_cnt_r <= tx_end ? 9'h000 : tx_cnt_r + 9'h001;
      if (tx_end) begin
        unique case (tx_state_r)
          TX_START: tx_state_r <= TX_DATA;
          TX_DATA: begin
            tx_bit_r <= 3'(tx_bit_r + 3'h1);
            if (tx_bit_r == (cfg.char8 ? 3'h7 : 3'h6)) begin
              tx_bit_r <= 3'h0;
              tx_state_r <= (cfg.parity == PAR_NONE) ? TX_STOP : TX_PAR;
            end
          end
          TX_PAR: tx_state_r <= TX_STOP;
          default: begin
            tx_bit_r <= 3'h1;
            if (!(cfg.stop2 && tx_bit_r == 3'h0)) begin
              tx_bit_r <= 3'h0;
              tx_state_r <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // transmit done pulse when the final stop bit has run its time
  always_ff @(posedge sys_clk) begin
    if (!rstn) transmit_done_irq_r <= 1'b0;
    else transmit_done_irq_r <= tx_end && tx_state_r == TX_STOP && txe_on &&
                                !(cfg.stop2 && tx_bit_r == 3'h0);
  end

  // output pin level and pin ownership
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      serial_out_pin_r <= 1'b1;
      out_pin_own_r <= 1'b0;
      in_pin_own_r <= 1'b0;
    end else begin
      serial_out_pin_r <= pwr ? (tx_lvl ^ cfg.invert) : 1'b1;
      out_pin_own_r <= txe_on;
      in_pin_own_r <= rxe_on;
    end
  end

  // input synchroniser; third flop only feeds the start edge detect
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_in_pin;
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_in;
    end
  end
  assign rx_in = pwr ? rx_s2_r : 1'b1;

  assign rx_end = tick_r && rx_cnt_r == bit_lim;

  // receiver runs beside the transmitter, sampling mid-bit
  always_ff @(posedge sys_clk) begin
    if (!rstn || !rxe_on) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= 9'h000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else if (rx_state_r == RX_IDLE) begin
      rx_cnt_r <= 9'h000;
      if (rx_prev_r && !rx_in) rx_state_r <= RX_START;
    end else if (rx_state_r == RX_START) begin
      if (tick_r) rx_cnt_r <= rx_cnt_r + 9'h001;
      if (tick_r && rx_cnt_r == half_lim) begin
        rx_cnt_r <= 9'h000;
        rx_sh_r <= 8'h00;
        rx_state_r <= rx_in ? RX_IDLE : RX_DATA; // glitch rejected
      end
    end else if (tick_r) begin
      rx_cnt_r <= rx_end ? 9'h000 : rx_cnt_r + 9'h001;
      if (rx_end) begin
        unique case (rx_state_r)
          RX_DATA: begin
            rx_sh_r[bit_index(cfg, rx_bit_r)] <= rx_in;
            rx_bit_r <= 3'(rx_bit_r + 3'h1);
            if (rx_bit_r == (cfg.char8 ? 3'h7 : 3'h6)) begin
              rx_bit_r <= 3'h0;
              rx_state_r <= (cfg.parity == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
          RX_PAR: begin
            rx_par_r <= rx_in;
            rx_state_r <= RX_STOP;
          end
          default: rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // frame checks at the first stop bit
  assign fe = !rx_in;
  assign pe = (cfg.parity == PAR_EVEN && (^(rx_sh_r & data_mask) ^ rx_par_r)) ||
              (cfg.parity == PAR_ODD && !(^(rx_sh_r & data_mask) ^ rx_par_r));
  assign ov = rx_full_r && !rd_rx;

  // receive buffer and its unread flag; a new frame wins over a read
  always_ff @(posedge sys_clk) begin
    if (!rstn || !pwr) begin
      rxbuf_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (rx_end && rx_state_r == RX_STOP) begin
      rxbuf_r <= rx_sh_r & data_mask;
      rx_full_r <= 1'b1;
    end else if (rd_rx) begin
      rx_full_r <= 1'b0;
    end
  end

  // sticky error flags, cleared by reading them, set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn || !pwr) err_r <= 8'h00;
    else if (rx_end && rx_state_r == RX_STOP)
      err_r <= (rd_err ? 8'h00 : err_r) | {5'h00, pe, fe, ov};
    else if (rd_err) err_r <= 8'h00;
  end

  // receive events; route bit sends errors to the done pulse as well
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      receive_done_irq_r <= 1'b0;
      receive_error_irq_r <= 1'b0;
    end else begin
      receive_done_irq_r <= rx_end && rx_state_r == RX_STOP &&
                            (!(pe || fe || ov) || mode_r[MODE_ROUTE]);
      receive_error_irq_r <= rx_end && rx_state_r == RX_STOP && (pe || fe || ov);
    end
  end

  // read data; transmit status is live so it follows the core
  always_ff @(posedge sys_clk) begin
    if (!rstn) cpu_rdata_r <= 8'h00;
    else if (cpu_rd) begin
      unique case (cpu_addr)
        ADDR_MODE: cpu_rdata_r <= mode_r;
        ADDR_CTRL: cpu_rdata_r <= ctrl_r;
        ADDR_BAUD: cpu_rdata_r <= baud_r;
        ADDR_CKS: cpu_rdata_r <= {4'h0, cks_r};
        ADDR_ERR: cpu_rdata_r <= err_r;
        ADDR_RXBUF: cpu_rdata_r <= rxbuf_r;
        ADDR_TXSTAT: cpu_rdata_r <= {6'h00, !fifo_ready, tx_state_r != TX_IDLE};
        default: cpu_rdata_r <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_mode_reset: assert property ($rose(rstn) |-> mode_r == MODE_RST)
    else $error("mode register not 01H after reset");
  chk_stop_pins: assert property (mode_r[7:5] == 3'h0 |=> !out_pin_own_r && !in_pin_own_r)
    else $error("pins kept while stopped");
  chk_off_high: assert property (!pwr |=> serial_out_pin_r && !tick_r)
    else $error("output not high or clock running with power off");
  chk_tx_hold: assert property (!txe_on |=> tx_state_r == TX_IDLE && !transmit_done_irq_r)
    else $error("transmitter ran while disabled");
  chk_rx_hold: assert property (!rxe_on |=> rx_state_r == RX_IDLE)
    else $error("receiver ran while disabled");
  chk_off_clear: assert property (!pwr ##1 !pwr |-> err_r == 8'h00 && rxbuf_r == 8'h00)
    else $error("status not cleared with power off");
  chk_start_low: assert property (tx_state_r == TX_START && txe_on |=> serial_out_pin_r == cfg.invert)
    else $error("start bit level wrong");
  chk_idle_level: assert property (txe_on && tx_state_r == TX_IDLE ##1 txe_on
                                   |-> serial_out_pin_r == !cfg.invert)
    else $error("idle level wrong");
  chk_done_stop: assert property (transmit_done_irq_r |-> $past(tx_state_r) == TX_STOP &&
                                  tx_state_r == TX_IDLE)
    else $error("done pulse not at end of stop bit");
  chk_even_par: assert property (tx_state_r == TX_PAR && cfg.parity == PAR_EVEN
                                 |=> (^(tx_sh_r & data_mask) ^ (serial_out_pin_r ^ cfg.invert)) == 1'b0
                                 || tx_state_r != TX_PAR)
    else $error("even parity bit wrong");

  cov_tx_done: cover property (transmit_done_irq_r);
  cov_rx_done: cover property (receive_done_irq_r);
  cov_rx_err: cover property (receive_error_irq_r && err_r[ERR_PARITY]);
  cov_duplex: cover property (tx_state_r == TX_DATA && rx_state_r == RX_DATA);
endmodule
`default_nettype wire

//--- verif/serial_peer.sv
// remote serial node: samples frames on the output line, sends frames on the input
// assumes idle-high lines and a bit time counted in system clock cycles
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic sys_clk,
  // serial lines
  input wire logic line_from_dut,
  output logic line_to_dut,
  // cells seen after the start bit
  output logic [10:0] rx_bits,
  output logic rx_strobe
);
  // sampler: a low level opens a frame, cells taken mid-bit
  initial begin
    rx_strobe = 1'h0;
    rx_bits = '1;
    line_to_dut = 1'h1; // idle high between frames
    forever begin
      @(posedge sys_clk);
      if (line_from_dut === 1'h0) begin
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < 11; i++) begin
          repeat (BIT_CYC) @(posedge sys_clk);
          rx_bits[i] = line_from_dut;
        end
        rx_strobe <= 1'h1;
        @(posedge sys_clk);
        rx_strobe <= 1'h0;
      end
    end
  end

  // sender: start bit then eleven cells; surplus cells are idle
  task automatic send(input logic [10:0] f);
    line_to_dut <= 1'h0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      line_to_dut <= f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    line_to_dut <= 1'h1;
  endtask
endmodule
`default_nettype wire

//--- verif/uart_mode_and_frame_control_tb_top.sv
// self-checking bench of the serial port: registers, framing, queue, power-down
// assumes the remote node model on both serial lines
`timescale 1ns/10ps
`default_nettype none
module uart_mode_and_frame_control_tb_top
  import uart_pkg::*;
;
  localparam int BT = 16; // divider 8, prescale 1
  logic sys_clk = 1'h0, rstn = 1'h0, cpu_wr = 1'h0, cpu_bit_wr = 1'h0;
  logic cpu_bit_val = 1'h0, cpu_rd = 1'h0, listen = 1'h0, inv_sel = 1'h0, rd_d = 1'h0;
  logic [15:0] cpu_addr = '0;
  logic [7:0] cpu_wdata = '0, cpu_rdata_r;
  logic [2:0] cpu_bit_sel = '0;
  logic serial_in_pin, serial_out_pin_r, out_pin_own_r, in_pin_own_r, peer_strobe;
  logic transmit_done_irq_r, receive_done_irq_r, receive_error_irq_r;
  logic [10:0] peer_bits;
  int fail_count = 0, tests_run = 0, tx_cnt = 0, rx_cnt = 0, err_cnt = 0, seed = 99134;
  logic [7:0] rd_q[$];
  logic [10:0] fr_q[$];

  always #50 sys_clk = ~sys_clk;

  uart_ctrl #(.FIFO_DEPTH(TX_FIFO_DEPTH)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel),
    .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .cpu_rdata_r(cpu_rdata_r),
    .serial_in_pin(serial_in_pin), .serial_out_pin_r(serial_out_pin_r),
    .out_pin_own_r(out_pin_own_r), .in_pin_own_r(in_pin_own_r),
    .transmit_done_irq_r(transmit_done_irq_r), .receive_done_irq_r(receive_done_irq_r),
    .receive_error_irq_r(receive_error_irq_r));

  // peer only listens while a frame is expected, so config glitches are not frames
  serial_peer #(.BIT_CYC(BT)) u_peer (
    .sys_clk(sys_clk), .line_from_dut(listen ? serial_out_pin_r ^ inv_sel : 1'h1),
    .line_to_dut(serial_in_pin), .rx_bits(peer_bits), .rx_strobe(peer_strobe));

  task automatic note(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, e, input string m);
    note(g === e, m);
  endtask
  task automatic cmp_frame(input logic [10:0] g, e, input string m);
    note(g === e, m);
  endtask
  task automatic cmp_bit(input logic g, e, input string m);
    note(g === e, m);
  endtask

  // watcher: oldest note against each read answer or captured frame
  always @(posedge sys_clk) begin
    if (rd_d) cmp_byte(cpu_rdata_r, rd_q.pop_front(), "read data");
    if (peer_strobe === 1'h1) cmp_frame(peer_bits, fr_q.pop_front(), "frame cells");
    if (transmit_done_irq_r === 1'h1) tx_cnt++;
    if (receive_done_irq_r === 1'h1) rx_cnt++;
    if (receive_error_irq_r === 1'h1) err_cnt++;
    rd_d <= cpu_rd;
  end

  // bus cycles: one strobe cycle, then a quiet one so no signal is set twice
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'h1;
    @(posedge sys_clk);
    cpu_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
    cpu_addr <= a;
    cpu_bit_sel <= s;
    cpu_bit_val <= v;
    cpu_bit_wr <= 1'h1;
    @(posedge sys_clk);
    cpu_bit_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    cpu_addr <= a;
    cpu_rd <= 1'h1;
    @(posedge sys_clk);
    cpu_rd <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic wait_cnt(ref int c, input int t, output int n);
    n = 0;
    while (c < t && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    note(c >= t, "event count");
  endtask

  // expected cells after the start bit; stop and idle cells stay high
  function automatic logic [10:0] frame_of(input logic [7:0] d, input frame_cfg_t c);
    logic [10:0] f;
    int n;
    logic p;
    f = '1;
    n = 0;
    p = 1'h0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || c.char8) begin
        f[n] = c.lsb_first ? d[i] : d[(c.char8 ? 7 : 6) - i];
        p ^= f[n];
        n++;
      end
    end
    if (c.parity == PAR_EVEN) f[n] = p;
    else if (c.parity == PAR_ODD) f[n] = ~p;
    else if (c.parity == PAR_ZERO) f[n] = 1'h0;
    return f;
  endfunction

  // reconfigure with both engines stopped, then enable them again
  task automatic setup(input frame_cfg_t c);
    listen <= 1'h0;
    wr(ADDR_MODE, {3'h4, c.parity, c.char8, c.stop2, 1'h0});
    bw(ADDR_CTRL, 3'(CTRL_DIR), c.lsb_first);
    bw(ADDR_CTRL, 3'(CTRL_INV), c.invert);
    bw(ADDR_MODE, 3'(MODE_TXE), 1'h1);
    bw(ADDR_MODE, 3'(MODE_RXE), 1'h1);
    cmp_bit(serial_out_pin_r, !c.invert, "idle level");
    inv_sel <= c.invert;
    listen <= 1'h1;
  endtask

  task automatic tx_one(input frame_cfg_t c, input logic [7:0] d);
    int n, len, b;
    len = (c.char8 ? 10 : 9) + (c.parity != PAR_NONE ? 1 : 0) + (c.stop2 ? 1 : 0);
    setup(c);
    b = tx_cnt;
    fr_q.push_back(frame_of(d, c));
    wr(ADDR_TXBUF, d);
    wait_cnt(tx_cnt, b + 1, n);
    note(n >= len * BT - 3 && n <= len * BT + 5, "frame duration");
    cmp_bit(serial_out_pin_r, !c.invert, "line after frame");
    repeat (2 * BT) @(posedge sys_clk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: roughly four times the expected run
  initial begin
    repeat (25000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    frame_cfg_t c;
    logic [7:0] d;
    int n, b, t;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    rd(ADDR_MODE, MODE_RST);
    rd(16'hFF5F, 8'h00);
    cmp_bit(out_pin_own_r, 1'h0, "pin owned when stopped");
    cmp_bit(serial_out_pin_r, 1'h1, "line high unpowered");
    // prescale 1 and divider 8 give the peer's 16-cycle bit time
    wr(ADDR_CKS, 8'h00);
    wr(ADDR_BAUD, 8'h08);
    rd(ADDR_BAUD, 8'h08);
    bw(ADDR_MODE, 3'(MODE_PWR), 1'h1);
    rd(ADDR_MODE, 8'h81);
    cmp_bit(serial_out_pin_r, 1'h1, "line high powered");
    wr(ADDR_TXBUF, 8'h5A);
    repeat (40) @(posedge sys_clk);
    cmp_bit(serial_out_pin_r, 1'h1, "write without enable");
    cmp_bit(out_pin_own_r, 1'h0, "out pin kept");
    bw(ADDR_MODE, 3'(MODE_TXE), 1'h1);
    // ownership flag follows the enable one edge after the write lands
    @(posedge sys_clk);
    cmp_bit(out_pin_own_r, 1'h1, "out pin taken");
    cmp_bit(in_pin_own_r, 1'h0, "in pin kept");
    b = tx_cnt;
    wr(ADDR_TXBUF, 8'hC3);
    repeat (3 * BT) @(posedge sys_clk);
    bw(ADDR_MODE, 3'(MODE_TXE), 1'h0);
    // the registered pin shows idle two edges after the enable drops
    repeat (2) @(posedge sys_clk);
    cmp_bit(serial_out_pin_r, 1'h1, "abort idles");
    rd(ADDR_TXSTAT, 8'h00);
    repeat (12 * BT) @(posedge sys_clk);
    note(tx_cnt == b, "no done after abort");
    $display("test start_up done");
    for (int i = 0; i < 8; i++) begin
      c = '{char8: i[2], parity: i[1:0], stop2: i[0], lsb_first: i[1], invert: i[2] ^ i[0]};
      tx_one(c, 8'($random(seed)));
    end
    $display("test framing done");
    // fill the queue past full while the first frame shifts out
    c = '{char8: 1'h1, parity: PAR_EVEN, stop2: 1'h1, lsb_first: 1'h1, invert: 1'h0};
    setup(c);
    b = tx_cnt;
    for (int i = 0; i < 18; i++) begin
      d = 8'($random(seed));
      if (i < 17) fr_q.push_back(frame_of(d, c));
      wr(ADDR_TXBUF, d);
      if (i == 16) rd(ADDR_TXSTAT, 8'h03);
    end
    wait_cnt(tx_cnt, b + 17, n);
    rd(ADDR_TXSTAT, 8'h00);
    repeat (2 * BT) @(posedge sys_clk);
    $display("test queue done");
    for (int p = 0; p < 2; p++) begin
      c = '{char8: 1'h1, parity: p ? PAR_ODD : PAR_EVEN, stop2: 1'h0, lsb_first: 1'h1,
            invert: 1'h0};
      setup(c);
      b = rx_cnt;
      t = tx_cnt;
      d = 8'($random(seed));
      fr_q.push_back(frame_of(d, c));
      fork
        u_peer.send(frame_of(~d, c));
        wr(ADDR_TXBUF, d);
      join
      wait_cnt(rx_cnt, b + 1, n);
      wait_cnt(tx_cnt, t + 1, n);
      rd(ADDR_RXBUF, ~d);
      rd(ADDR_ERR, 8'h00);
      u_peer.send(frame_of(d, c) ^ 11'h100);
      wait_cnt(err_cnt, p + 1, n);
      if (p == 0) rd(ADDR_ERR, 8'h04);
      // read the bad frame out, else the next pass sees an overrun
      rd(ADDR_RXBUF, d);
    end
    $display("test receive done");
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_MODE, 8'h00);
    cmp_bit(out_pin_own_r | in_pin_own_r, 1'h0, "pins released");
    cmp_bit(serial_out_pin_r, 1'h1, "line high after stop");
    rd(ADDR_ERR, 8'h00);
    rd(ADDR_RXBUF, 8'h00);
    rd(ADDR_TXSTAT, 8'h00);
    $display("test power_down done");
    complete_run();
  end
endmodule
`default_nettype wire
